//--- shared/seq_pkg.sv
// Constants for the clock and reset sequencer.
package seq_pkg;
   localparam int CLK_MHZ = 125;
   localparam int POR_TIME_US = 23000;
   localparam int PIN_TIME_US = 760;
   localparam int PHY_TIME_US = 110;
   localparam int VPHY_TIME_US = 1;
   localparam int BYTE_TWO_WIRE_US = 91;
   localparam int BYTE_THREE_WIRE_US = 28;
   localparam int SERIAL_RESET_US = 10;
   localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
   localparam int PIN_CYCLES = PIN_TIME_US * CLK_MHZ;
   localparam int PHY_CYCLES = PHY_TIME_US * CLK_MHZ;
   localparam int VPHY_CYCLES = VPHY_TIME_US * CLK_MHZ;
   localparam int BYTE_TWO_WIRE_CYCLES = BYTE_TWO_WIRE_US * CLK_MHZ;
   localparam int BYTE_THREE_WIRE_CYCLES = BYTE_THREE_WIRE_US * CLK_MHZ;
   localparam int SERIAL_RESET_CYCLES = SERIAL_RESET_US * CLK_MHZ;
   localparam int MAX_BYTES_TWO_WIRE = 65536;
   localparam int MAX_BYTES_THREE_WIRE = 2048;
   localparam logic [31:0] BYTE_ORDER_PATTERN = 32'h87654321;
   localparam logic [31:0] BYTE_ORDER_INVALID = 32'h00000000;
   localparam int TIMER_DIV = 125;
   localparam int STRAP_W = 8;
   localparam int IMMUNE_W = 8;
   localparam int CNT_W = 32;
   typedef enum logic [2:0] {S_CHIP, S_SERIAL, S_BASE, S_LOAD, S_READY} seq_state_e;
endpackage : seq_pkg

//--- src/clock_reset_sequencer.sv
// Clock and reset sequencer: chip, digital and PHY resets with ready reporting.
`timescale 1ns/1ps
`default_nettype none
module clock_reset_sequencer
   import seq_pkg::*;
#(
   parameter int POR_CNT = POR_CYCLES,
   parameter int PIN_CNT = PIN_CYCLES,
   parameter int PHY_CNT = PHY_CYCLES,
   parameter int VPHY_CNT = VPHY_CYCLES,
   parameter int SERIAL_CNT = SERIAL_RESET_CYCLES,
   parameter int BYTE2_CNT = BYTE_TWO_WIRE_CYCLES,
   parameter int BYTE3_CNT = BYTE_THREE_WIRE_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ext_reset_pin_n,
   input wire logic [STRAP_W-1:0] strap_pins,
   input wire logic eeprom_three_wire,
   input wire logic [16:0] eeprom_byte_count,
   input wire logic digital_reset_req,
   input wire logic port_one_phy_reset_req,
   input wire logic port_two_phy_reset_req,
   input wire logic virtual_phy_reset_req,
   input wire logic write_req,
   input wire logic [IMMUNE_W-1:0] immune_wdata,
   output logic [STRAP_W-1:0] strap_latched,
   output logic eeprom_load_start,
   output logic eeprom_loading,
   output logic [31:0] byte_order_value,
   output logic ready,
   output logic write_accepted,
   output logic [IMMUNE_W-1:0] soft_reset_immune_bits,
   output logic chip_domain_rst_n,
   output logic digital_domain_rst_n,
   output logic serial_domain_rst_n,
   output logic port_one_phy_rst_n,
   output logic port_two_phy_rst_n,
   output logic virtual_phy_rst_n,
   output logic port_one_phy_reset_bit,
   output logic port_two_phy_reset_bit,
   output logic virtual_phy_reset_bit,
   output logic timer_tick,
   output logic free_run_tick
);
   // Every phase needs a cycle, and the base phase must outlast the serial phase it includes.
   if (POR_CNT <= SERIAL_CNT || PIN_CNT <= SERIAL_CNT || PHY_CNT < 1 || VPHY_CNT < 1 || SERIAL_CNT < 1
       || BYTE2_CNT < 1 || BYTE3_CNT < 1) begin : g_bad_counts
      $error("Sequencer counts must be positive and base counts above the serial count.");
   end

   logic pin_s1_reg, pin_s2_reg;
   logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;
   seq_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [16:0] bytes_reg, bytes_next;
   logic pin_cause_reg, pin_cause_next;
   logic [STRAP_W-1:0] strap_reg, strap_next;
   logic [IMMUNE_W-1:0] immune_reg, immune_next;
   logic start_reg, start_next;
   logic [CNT_W-1:0] p1_cnt_reg, p1_cnt_next, p2_cnt_reg, p2_cnt_next, vp_cnt_reg, vp_cnt_next;
   logic [7:0] tdiv_reg, tdiv_next;
   logic tick_reg, tick_next;
   logic [1:0] free_reg, free_next;

   // Counter load helper shared by every timed phase.
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction : cyc

   // Pin synchroniser resets to the pulled-up idle level, so power-on is not mistaken for a pin reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
      end else begin
         pin_s1_reg <= ext_reset_pin_n;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Strap synchroniser has no reset, so the straps are settled before power-on reset releases.
   always_ff @(posedge clk) begin
      strap_s1_reg <= strap_pins;
      strap_s2_reg <= strap_s1_reg;
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bytes_next = bytes_reg;
      pin_cause_next = pin_cause_reg;
      strap_next = strap_reg;
      immune_next = immune_reg;
      start_next = 1'b0;
      if (!pin_s2_reg) begin
         state_next = S_CHIP;
         pin_cause_next = 1'b1;
         cnt_next = '0;
         // Only chip reset clears immune bits
         immune_next = '0;
      end else begin
         case (state_reg)
            S_CHIP: begin
               strap_next = strap_s2_reg;
               state_next = S_SERIAL;
               cnt_next = cyc(SERIAL_CNT);
            end
            S_SERIAL: begin
               if (cnt_reg == '0) begin
                  state_next = S_BASE;
                  cnt_next = pin_cause_reg ? cyc(PIN_CNT - SERIAL_CNT) : cyc(POR_CNT - SERIAL_CNT);
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            S_BASE: begin
               if (cnt_reg == '0) begin
                  start_next = 1'b1;
                  state_next = S_LOAD;
                  if (eeprom_three_wire && eeprom_byte_count > 17'(MAX_BYTES_THREE_WIRE)) begin
                     bytes_next = 17'(MAX_BYTES_THREE_WIRE);
                  end else if (eeprom_byte_count > 17'(MAX_BYTES_TWO_WIRE)) begin
                     bytes_next = 17'(MAX_BYTES_TWO_WIRE);
                  end else begin
                     bytes_next = eeprom_byte_count;
                  end
                  cnt_next = eeprom_three_wire ? cyc(BYTE3_CNT) : cyc(BYTE2_CNT);
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            S_LOAD: begin
               if (bytes_reg == '0) begin
                  state_next = S_READY;
               end else if (cnt_reg == '0) begin
                  bytes_next = bytes_reg - 1'b1;
                  cnt_next = eeprom_three_wire ? cyc(BYTE3_CNT) : cyc(BYTE2_CNT);
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            default: begin
               if (write_req) begin
                  immune_next = immune_wdata;
               end
               if (digital_reset_req) begin
                  state_next = S_SERIAL;
                  pin_cause_next = 1'b1;
                  cnt_next = cyc(SERIAL_CNT);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_CHIP;
         cnt_reg <= '0;
         bytes_reg <= '0;
         pin_cause_reg <= 1'b0;
         strap_reg <= '0;
         immune_reg <= '0;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bytes_reg <= bytes_next;
         pin_cause_reg <= pin_cause_next;
         strap_reg <= strap_next;
         immune_reg <= immune_next;
         start_reg <= start_next;
      end
   end

   // PHY single-module resets; a new request restarts its own timer only.
   always_comb begin
      p1_cnt_next = p1_cnt_reg;
      p2_cnt_next = p2_cnt_reg;
      vp_cnt_next = vp_cnt_reg;
      if (state_reg == S_CHIP || !pin_s2_reg) begin
         p1_cnt_next = cyc(PHY_CNT);
         p2_cnt_next = cyc(PHY_CNT);
         vp_cnt_next = cyc(VPHY_CNT);
      end else begin
         if (port_one_phy_reset_req && state_reg == S_READY) begin
            p1_cnt_next = cyc(PHY_CNT) + 1'b1;
         end else if (p1_cnt_reg != '0) begin
            p1_cnt_next = p1_cnt_reg - 1'b1;
         end
         if (port_two_phy_reset_req && state_reg == S_READY) begin
            p2_cnt_next = cyc(PHY_CNT) + 1'b1;
         end else if (p2_cnt_reg != '0) begin
            p2_cnt_next = p2_cnt_reg - 1'b1;
         end
         if (virtual_phy_reset_req && state_reg == S_READY) begin
            vp_cnt_next = cyc(VPHY_CNT) + 1'b1;
         end else if (vp_cnt_reg != '0) begin
            vp_cnt_next = vp_cnt_reg - 1'b1;
         end
      end
      tick_next = (tdiv_reg == 8'(TIMER_DIV - 1));
      tdiv_next = tick_next ? 8'h00 : tdiv_reg + 8'h01;
      free_next = free_reg + 2'h1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      // PHYs stay in reset while power-on reset is held.
      if (!rstn) begin
         p1_cnt_reg <= CNT_W'(PHY_CNT);
         p2_cnt_reg <= CNT_W'(PHY_CNT);
         vp_cnt_reg <= CNT_W'(VPHY_CNT);
         tdiv_reg <= 8'h00;
         tick_reg <= 1'b0;
         free_reg <= 2'h0;
      end else begin
         p1_cnt_reg <= p1_cnt_next;
         p2_cnt_reg <= p2_cnt_next;
         vp_cnt_reg <= vp_cnt_next;
         tdiv_reg <= tdiv_next;
         tick_reg <= tick_next;
         free_reg <= free_next;
      end
   end

   assign chip_domain_rst_n = (state_reg != S_CHIP);
   assign serial_domain_rst_n = (state_reg != S_CHIP) && (state_reg != S_SERIAL);
   assign digital_domain_rst_n = serial_domain_rst_n;
   assign port_one_phy_rst_n = (p1_cnt_reg == '0);
   assign port_two_phy_rst_n = (p2_cnt_reg == '0);
   assign virtual_phy_rst_n = (vp_cnt_reg == '0);
   assign port_one_phy_reset_bit = (p1_cnt_reg != '0);
   assign port_two_phy_reset_bit = (p2_cnt_reg != '0);
   assign virtual_phy_reset_bit = (vp_cnt_reg != '0);
   assign byte_order_value = serial_domain_rst_n ? BYTE_ORDER_PATTERN : BYTE_ORDER_INVALID;
   assign ready = (state_reg == S_READY);
   assign write_accepted = ready && write_req;
   assign eeprom_load_start = start_reg;
   assign eeprom_loading = (state_reg == S_LOAD);
   assign strap_latched = strap_reg;
   assign soft_reset_immune_bits = immune_reg;
   // Clocks come from base PLL outside
   assign timer_tick = tick_reg;
   assign free_run_tick = free_reg[1];
endmodule : clock_reset_sequencer
`default_nettype wire

//--- dv/seq_monitor.sv
// Concurrent checks on the clock and reset sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module seq_monitor
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ext_reset_pin_n,
   input wire logic digital_reset_req,
   input wire logic write_req,
   input wire logic [STRAP_W-1:0] strap_latched,
   input wire logic eeprom_load_start,
   input wire logic [31:0] byte_order_value,
   input wire logic ready,
   input wire logic write_accepted,
   input wire logic serial_domain_rst_n,
   input wire logic port_one_phy_rst_n,
   input wire logic port_two_phy_rst_n,
   input wire logic virtual_phy_rst_n,
   input wire logic port_one_phy_reset_bit
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic phys_up;
   assign phys_up = port_one_phy_rst_n & port_two_phy_rst_n & virtual_phy_rst_n;
   chk_write_gate: assert property (write_req && !ready |-> !write_accepted)
      else $error("write accepted while not ready");
   chk_byte_invalid: assert property (!serial_domain_rst_n && $past(serial_domain_rst_n) == 1'b0
      |-> byte_order_value == BYTE_ORDER_INVALID)
      else $error("byte order valid during serial reset");
   chk_ready_pattern: assert property (ready |-> byte_order_value == BYTE_ORDER_PATTERN)
      else $error("ready without byte order pattern");
   chk_digital_drop: assert property (digital_reset_req && ready |=> !ready)
      else $error("digital reset did not drop ready");
   chk_phy_spared: assert property (digital_reset_req && ready && phys_up |=> phys_up)
      else $error("digital reset touched a phy");
   chk_strap_keep: assert property ($fell(ready) && ext_reset_pin_n |-> ##1 $stable(strap_latched)[*4])
      else $error("straps changed on digital reset");
   chk_phy_clear: assert property ($rose(port_one_phy_reset_bit) |-> ##[1:200] !port_one_phy_reset_bit)
      else $error("phy reset bit did not clear");
   chk_no_load_single: assert property (ready && !digital_reset_req && ext_reset_pin_n
      |=> !eeprom_load_start)
      else $error("loader started without cause");
   cov_digital: cover property (digital_reset_req && ready);
   cov_phy: cover property ($rose(port_one_phy_reset_bit));
   cov_write: cover property (write_accepted);
endmodule : seq_monitor
`default_nettype wire

//--- dv/mgmt_host_model.sv
// Management host that polls byte order first and then the ready flag.
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [31:0] byte_order_value,
   input wire logic ready,
   output logic host_ok,
   output logic order_err
);
   logic pattern_seen;
   // Polls only byte order then ready.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_ok <= 1'b0;
         order_err <= 1'b0;
         pattern_seen <= 1'b0;
      end else if (ready !== 1'b1) begin
         host_ok <= 1'b0;
         pattern_seen <= (byte_order_value === BYTE_ORDER_PATTERN);
      end else begin
         if (!pattern_seen && !host_ok) order_err <= 1'b1;
         host_ok <= 1'b1;
      end
   end
endmodule : mgmt_host_model
`default_nettype wire

//--- dv/tb.sv
// Testbench for the clock and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb
   import seq_pkg::*;
;
   logic clk = 1'b0, rstn = 1'b0, pin_n = 1'b1, three = 1'b0, wr = 1'b0, host_ok, order_err;
   logic [3:0] req = 4'h0;
   logic [7:0] straps = 8'hA5, wdata = 8'h00, strap_q, immune_q;
   logic [16:0] bytes = 17'h00003;
   logic [31:0] bo;
   logic ld, rdy, p1, p2, pv, b1, b2, bv, cr, dr, sr, tt, ft;
   int bad_count = 0, samples_checked = 0, loads = 0, n;
   int ticks = 0, fhi = 0, t0, f0;
   always #4 clk = ~clk;
   always @(posedge clk) if (ld === 1'b1) loads++;
   always @(posedge clk) begin
      if (tt === 1'b1) ticks++;
      if (ft === 1'b1) fhi++;
   end
   clock_reset_sequencer #(.POR_CNT(12), .PIN_CNT(10), .PHY_CNT(6), .VPHY_CNT(3), .SERIAL_CNT(4),
      .BYTE2_CNT(5), .BYTE3_CNT(3)) DUT (.clk, .rstn, .ext_reset_pin_n(pin_n), .strap_pins(straps),
      .eeprom_three_wire(three), .eeprom_byte_count(bytes), .digital_reset_req(req[0]),
      .port_one_phy_reset_req(req[1]), .port_two_phy_reset_req(req[2]), .virtual_phy_reset_req(req[3]),
      .write_req(wr), .immune_wdata(wdata), .strap_latched(strap_q), .eeprom_load_start(ld),
      .eeprom_loading(), .byte_order_value(bo), .ready(rdy), .write_accepted(),
      .soft_reset_immune_bits(immune_q), .chip_domain_rst_n(cr), .digital_domain_rst_n(dr),
      .serial_domain_rst_n(sr), .port_one_phy_rst_n(p1), .port_two_phy_rst_n(p2), .virtual_phy_rst_n(pv),
      .port_one_phy_reset_bit(b1), .port_two_phy_reset_bit(b2), .virtual_phy_reset_bit(bv),
      .timer_tick(tt), .free_run_tick(ft));
   mgmt_host_model host (.clk, .rstn, .byte_order_value(bo), .ready(rdy), .host_ok, .order_err);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic wait_ready(output int c);
      c = 0;
      while (rdy !== 1'b1 || host_ok !== 1'b1) begin
         tick(1);
         c++;
         if (c > 20000) begin
            bad_count++;
            final_report();
         end
      end
   endtask : wait_ready
   task automatic pulse(input int i);
      @(posedge clk) req[i] <= 1'b1;
      @(posedge clk) req[i] <= 1'b0;
      #1;
   endtask : pulse
   initial begin
      tick(10);
      @(posedge clk) rstn <= 1'b1;
      @(posedge clk) wr <= 1'b1;
      wdata <= 8'h3C;
      @(posedge clk) wr <= 1'b0;
      wait_ready(n);
      check(strap_q, 8'hA5);
      check(immune_q, 8'h00);
      check(loads, 1);
      check(bo, BYTE_ORDER_PATTERN);
      check(order_err, 1'b0);
      check({cr, dr, sr}, 3'b111);
      t0 = ticks;
      f0 = fhi;
      tick(TIMER_DIV * 4);
      check(ticks - t0, 4);
      check(fhi - f0, TIMER_DIV * 2);
      @(posedge clk) wr <= 1'b1;
      wdata <= 8'h5A;
      @(posedge clk) wr <= 1'b0;
      tick(1);
      check(immune_q, 8'h5A);
      for (int i = 1; i < 4; i++) begin
         pulse(i);
         check({bv, b2, b1}, 3'b001 << (i - 1));
         check(rdy, 1'b1);
         n = 0;
         while ({bv, b2, b1} !== 3'b000 && n < 50) begin
            tick(1);
            n++;
         end
         check({bv, b2, b1}, 3'b000);
         check(n, (i == 3) ? 3 : 6);
      end
      check(loads, 1);
      @(posedge clk);
      straps <= 8'h0F;
      three <= 1'b1;
      bytes <= 17'h1FFFF;
      pulse(0);
      check(rdy, 1'b0);
      check({pv, p2, p1}, 3'b111);
      check(bo, BYTE_ORDER_INVALID);
      check({cr, dr, sr}, 3'b100);
      wait_ready(n);
      check(n >= MAX_BYTES_THREE_WIRE * 3, 1'b1);
      check(strap_q, 8'hA5);
      check(immune_q, 8'h5A);
      check(loads, 2);
      @(posedge clk) pin_n <= 1'b0;
      three <= 1'b0;
      bytes <= 17'h00003;
      tick(4);
      @(posedge clk) pin_n <= 1'b1;
      wait_ready(n);
      check(n >= 10 + 3 * 5, 1'b1);
      check(immune_q, 8'h00);
      check(strap_q, 8'h0F);
      check(loads, 3);
      final_report();
   end
endmodule : tb
bind clock_reset_sequencer seq_monitor mon (.clk, .rstn, .ext_reset_pin_n, .digital_reset_req, .write_req,
   .strap_latched, .eeprom_load_start, .byte_order_value, .ready, .write_accepted, .serial_domain_rst_n,
   .port_one_phy_rst_n, .port_two_phy_rst_n, .virtual_phy_rst_n, .port_one_phy_reset_bit);
`default_nettype wire
